//--- csrc_regs.vh
`ifndef CSRC_REGS_VH
`define CSRC_REGS_VH

// Chip-select counts and field widths
`define CSRC_NUM_SEL         11
`define CSRC_PAR_W           2
`define CSRC_BASE_W          13
`define CSRC_BLK_W           3
`define CSRC_OPT_W           16

// Base register layout: base [15:3], block size [2:0]
`define CSRC_BASE_MSB        15
`define CSRC_BASE_LSB        3
`define CSRC_BLK_MSB         2
`define CSRC_BLK_LSB         0

// Option register layout
`define CSRC_OPT_MODE        15
`define CSRC_OPT_BYTE_MSB    14
`define CSRC_OPT_BYTE_LSB    13
`define CSRC_OPT_RW_MSB      12
`define CSRC_OPT_RW_LSB      11
`define CSRC_OPT_STRB        10
`define CSRC_OPT_ACK_MSB     9
`define CSRC_OPT_ACK_LSB     6
`define CSRC_OPT_SPACE_MSB   5
`define CSRC_OPT_SPACE_LSB   4
`define CSRC_OPT_IPL_MSB     3
`define CSRC_OPT_IPL_LSB     1
`define CSRC_OPT_AUTOVECTOR_SELECT        0

// Block size codes
`define CSRC_BLK_2K          3'h0
`define CSRC_BLK_1M          3'h7

// Field codes
`define CSRC_MODE_ASYNC      1'h0
`define CSRC_BYTE_OFF        2'h0
`define CSRC_BYTE_BOTH       2'h3
`define CSRC_RW_RSVD         2'h0
`define CSRC_RW_BOTH         2'h3
`define CSRC_STRB_AS         1'h0
`define CSRC_ACK_0WAIT       4'h0
`define CSRC_ACK_13WAIT      4'hD
`define CSRC_SPACE_CPU       2'h0
`define CSRC_SPACE_SU        2'h3
`define CSRC_IPL_ANY         3'h0
`define CSRC_AUTOVECTOR_SELECT_EXT        1'h0

// Reset values
`define CSRC_BASE_RST        13'h0000
`define CSRC_BOOT_VEC_ADDR   24'h000000

`endif

//--- csrc_strap_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for strap pins
module csrc_strap_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

	reg [W-1:0] stage1;

	// First stage only feeds second
	always @(posedge clk) begin
		stage1 <= din;
		dout   <= stage1;
	end

endmodule

`default_nettype wire

//--- csrc_top.v
`include "csrc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module csrc_top (
	// Clock and reset
	input  wire        CORE_CLK,
	input  wire        RST,
	// Data bus strap inputs
	input  wire [7:0]  DATA_IN,
	// Pull-up enable for strap lines
	output reg         DATA_PULLUP_EN,
	// Software write port
	input  wire        WR_EN,
	input  wire [3:0]  WR_SEL,
	input  wire [1:0]  WR_FIELD,
	input  wire [15:0] WR_DATA,
	// Access for boot decode
	input  wire        ACC_VALID,
	input  wire [23:0] ACC_ADDR,
	input  wire        ACC_RW,
	input  wire [1:0]  ACC_SPACE,
	// Pin-function fields
	output reg  [21:0]  SELECT_PIN_FUNCTION,
	output reg  [1:0]   BOOT_PIN_FUNCTION,
	// Boot base and option
	output reg  [15:0]  BOOT_SELECT_BASE_REG,
	output reg  [15:0]  BOOT_SELECT_OPTION_REG,
	// General base and option
	output reg  [175:0] SELECT_BASE_ADDRESS_REG,
	output reg  [175:0] SELECT_OPTION_REG,
	// Boot port width
	output reg          BOOT_PORT_16,
	// Boot select output, active low
	output reg          BOOT_SELECT_OUTPUT_N,
	// First vector fetch seen
	output reg          FIRST_FETCH_DONE
);

	////////////////////////////////////////////////////////////////////////
	// Write field codes
	localparam [1:0] FLD_PAR  = 2'h0;
	localparam [1:0] FLD_BASE = 2'h1;
	localparam [1:0] FLD_OPT  = 2'h2;
	localparam [3:0] SEL_BOOT = 4'hB;

	// First-fetch tracker states
	localparam [1:0] ST_RESET = 2'h0;
	localparam [1:0] ST_FETCH = 2'h1;
	localparam [1:0] ST_RUN   = 2'h2;

	// General select reset words
	localparam [15:0] GEN_BASE_RST = {
		`CSRC_BASE_RST,   // Base address zero
		`CSRC_BLK_2K      // 2K block
	};
	localparam [15:0] GEN_OPT_RST = {
		`CSRC_MODE_ASYNC, // Asynchronous mode
		`CSRC_BYTE_OFF,   // Byte lanes disabled
		`CSRC_RW_RSVD,    // Reserved read/write code
		`CSRC_STRB_AS,    // Address strobe timing
		`CSRC_ACK_0WAIT,  // No wait states
		`CSRC_SPACE_CPU,  // CPU space
		`CSRC_IPL_ANY,    // Any interrupt level
		`CSRC_AUTOVECTOR_SELECT_EXT    // External vector
	};

	// Boot select reset words
	localparam [15:0] BOOT_BASE_RST = {
		`CSRC_BASE_RST,   // Base address zero
		`CSRC_BLK_1M      // 1M block
	};
	localparam [15:0] BOOT_OPT_RST = {
		`CSRC_MODE_ASYNC, // Asynchronous mode
		`CSRC_BYTE_BOTH,  // Both byte lanes
		`CSRC_RW_BOTH,    // Read and write
		`CSRC_STRB_AS,    // Address strobe timing
		`CSRC_ACK_13WAIT, // Thirteen wait states
		`CSRC_SPACE_SU,   // Supervisor and user space
		`CSRC_IPL_ANY,    // Any interrupt level
		`CSRC_AUTOVECTOR_SELECT_EXT    // External vector
	};

	// Internal state
	wire [7:0]  data_sync;
	reg  [10:0] strap_high;
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg         wr_pin_fn;
	reg         wr_base;
	reg         wr_opt;
	reg         sel_boot;
	reg         sel_gen;
	reg         lane_on;
	reg         addr_hit;
	reg         rw_hit;
	reg         space_hit;
	reg         vec_fetch;
	reg         boot_hit;
	reg  [23:0] blk_mask;
	reg  [23:0] boot_base_addr;
	integer     i;
	integer     j;
	integer     k;

	////////////////////////////////////////////////////////////////////////
	// Strap synchroniser
	csrc_strap_sync #(
		.W(8)
	) u_sync (
		.clk  (CORE_CLK),
		.din  (DATA_IN),
		.dout (data_sync)
	);

	// Weak pull-ups live while in reset
	always @(posedge CORE_CLK) begin
		DATA_PULLUP_EN <= RST;
	end

	// Map the eleven general straps onto data lines 7..1
	always @* begin
		strap_high = 11'h000;
		for (j = 0; j < `CSRC_NUM_SEL; j = j + 1) begin
			strap_high[j] = data_sync[j % 7 + 1];
		end
	end

	// Write decode by field and select; selects above boot are ignored
	always @* begin
		wr_pin_fn = WR_EN && (WR_FIELD == FLD_PAR);
		wr_base   = WR_EN && (WR_FIELD == FLD_BASE);
		wr_opt    = WR_EN && (WR_FIELD == FLD_OPT);
		sel_boot  = (WR_SEL == SEL_BOOT);
		sel_gen   = (WR_SEL < SEL_BOOT);
	end

	////////////////////////////////////////////////////////////////////////
	// General pin-function fields: strap capture in reset, software writes after
	always @(posedge CORE_CLK) begin
		if (RST) begin
			for (i = 0; i < `CSRC_NUM_SEL; i = i + 1) begin
				SELECT_PIN_FUNCTION[2*i]   <= 1'h1;
				SELECT_PIN_FUNCTION[2*i+1] <= strap_high[i];
			end
		end else if (wr_pin_fn && sel_gen) begin
			SELECT_PIN_FUNCTION[2*WR_SEL +: 2] <= WR_DATA[1:0];
		end
	end

	// Boot pin-function field: select bit set in reset, width strap on the low bit; software writes after
	always @(posedge CORE_CLK) begin
		if (RST) begin
			BOOT_PIN_FUNCTION <= {1'h1, data_sync[0]};
		end else if (wr_pin_fn && sel_boot) begin
			BOOT_PIN_FUNCTION <= WR_DATA[1:0];
		end
	end

	// Boot port width; tracks the strap in reset so it agrees at release
	always @(posedge CORE_CLK) begin
		if (RST) begin
			BOOT_PORT_16 <= data_sync[0];
		end else begin
			BOOT_PORT_16 <= BOOT_PIN_FUNCTION[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// General base and option registers
	always @(posedge CORE_CLK) begin
		if (RST) begin
			for (k = 0; k < `CSRC_NUM_SEL; k = k + 1) begin
				SELECT_BASE_ADDRESS_REG[16*k +: 16] <= GEN_BASE_RST;
				SELECT_OPTION_REG[16*k +: 16]       <= GEN_OPT_RST;
			end
		end else if (sel_gen) begin
			if (wr_base) begin
				SELECT_BASE_ADDRESS_REG[16*WR_SEL +: 16] <= WR_DATA;
			end
			if (wr_opt) begin
				SELECT_OPTION_REG[16*WR_SEL +: 16] <= WR_DATA;
			end
		end
	end

	// Boot base register
	always @(posedge CORE_CLK) begin
		if (RST) begin
			BOOT_SELECT_BASE_REG <= BOOT_BASE_RST;
		end else if (wr_base && sel_boot) begin
			BOOT_SELECT_BASE_REG <= WR_DATA;
		end
	end

	// Boot option register
	always @(posedge CORE_CLK) begin
		if (RST) begin
			BOOT_SELECT_OPTION_REG <= BOOT_OPT_RST;
		end else if (wr_opt && sel_boot) begin
			BOOT_SELECT_OPTION_REG <= WR_DATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Block-size address mask: 2K, 8K, 32K, 64K, 128K, 256K, 512K, 1M for codes 0 to 7
	always @* begin
		case (BOOT_SELECT_BASE_REG[`CSRC_BLK_MSB:`CSRC_BLK_LSB])
			3'h0:    blk_mask = 24'hFFF800;
			3'h1:    blk_mask = 24'hFFE000;
			3'h2:    blk_mask = 24'hFF8000;
			3'h3:    blk_mask = 24'hFF0000;
			3'h4:    blk_mask = 24'hFE0000;
			3'h5:    blk_mask = 24'hFC0000;
			3'h6:    blk_mask = 24'hF80000;
			default: blk_mask = 24'hF00000;
		endcase
	end

	// Boot base field widened to a byte address
	always @* begin
		boot_base_addr = {BOOT_SELECT_BASE_REG[`CSRC_BASE_MSB:`CSRC_BASE_LSB], 11'h000};
	end

	// Boot select match terms
	always @* begin
		lane_on   = (BOOT_SELECT_OPTION_REG[`CSRC_OPT_BYTE_MSB:`CSRC_OPT_BYTE_LSB]
			!= `CSRC_BYTE_OFF);
		addr_hit  = ((ACC_ADDR & blk_mask) == (boot_base_addr & blk_mask));
		rw_hit    = ACC_RW ? BOOT_SELECT_OPTION_REG[`CSRC_OPT_RW_LSB]
			: BOOT_SELECT_OPTION_REG[`CSRC_OPT_RW_MSB];
		space_hit = ((BOOT_SELECT_OPTION_REG[`CSRC_OPT_SPACE_MSB:`CSRC_OPT_SPACE_LSB]
			& ACC_SPACE) != 2'h0);
	end

	// Boot select decode; the pin must be in select function
	always @* begin
		boot_hit = ACC_VALID && BOOT_PIN_FUNCTION[1] && lane_on && addr_hit
			&& rw_hit && space_hit;
	end

	////////////////////////////////////////////////////////////////////////
	// Supervisor access to the reset vector
	always @* begin
		vec_fetch = ACC_VALID && (ACC_ADDR == `CSRC_BOOT_VEC_ADDR) && ACC_SPACE[1];
	end

	// First-fetch tracker
	always @* begin
		case (state)
			ST_RESET: next_state = ST_FETCH;
			ST_FETCH: next_state = vec_fetch ? ST_RUN : ST_FETCH;
			ST_RUN:   next_state = ST_RUN;
			default:  next_state = ST_RESET;
		endcase
	end

	// First-fetch state register
	always @(posedge CORE_CLK) begin
		if (RST) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// First-fetch flag, sticky until the next reset
	always @(posedge CORE_CLK) begin
		if (RST) begin
			FIRST_FETCH_DONE <= 1'h0;
		end else begin
			FIRST_FETCH_DONE <= (next_state == ST_RUN);
		end
	end

	// Boot select output, one cycle after the access
	always @(posedge CORE_CLK) begin
		if (RST) begin
			BOOT_SELECT_OUTPUT_N <= 1'h1;
		end else begin
			BOOT_SELECT_OUTPUT_N <= ~boot_hit;
		end
	end

endmodule

`default_nettype wire

//--- csrc_strap_drv.sv
`timescale 1ns/1ps
`default_nettype none
module csrc_strap_drv (
	// Bench control
	input wire logic       drive,
	input wire logic [7:0] level,
	// Pull-up request from the block
	input wire logic       pullup_en,
	// Strap lines
	output logic [7:0]     data_lines
);
	// Driven level wins, then pull-ups, else a floating pattern
	assign data_lines = drive ? level : pullup_en ? 8'hFF : ~level;
endmodule
`default_nettype wire

//--- csrc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csrc_checker (
	// Clock, reset, inputs
	input wire logic         CORE_CLK,
	input wire logic         RST,
	input wire logic [7:0]   DATA_IN,
	input wire logic         WR_EN,
	input wire logic         ACC_VALID,
	input wire logic [23:0]  ACC_ADDR,
	input wire logic         ACC_RW,
	input wire logic [1:0]   ACC_SPACE,
	// Outputs
	input wire logic [21:0]  SELECT_PIN_FUNCTION,
	input wire logic [1:0]   BOOT_PIN_FUNCTION,
	input wire logic [15:0]  BOOT_SELECT_BASE_REG,
	input wire logic [15:0]  BOOT_SELECT_OPTION_REG,
	input wire logic [175:0] SELECT_OPTION_REG,
	input wire logic         BOOT_PORT_16,
	input wire logic         DATA_PULLUP_EN,
	input wire logic         BOOT_SELECT_OUTPUT_N
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// Reset-vector read and reset boot setup
	sequence s_vec_read;
		ACC_VALID && ACC_ADDR == 24'h000000 && ACC_RW && ACC_SPACE[1];
	endsequence
	sequence s_boot_rst;
		BOOT_SELECT_BASE_REG == 16'h0007 && BOOT_SELECT_OPTION_REG == 16'h7B70;
	endsequence
	chk_gen_low_ones: assert property ($fell(RST) |->
		(SELECT_PIN_FUNCTION & 22'h155555) == 22'h155555) else $error("pin low bits");
	chk_gen_strap_bit: assert property ($fell(RST) |->
		SELECT_PIN_FUNCTION[1] == $past(DATA_IN[1], 3)) else $error("pin strap bit");
	chk_boot_width: assert property ($fell(RST) |-> BOOT_PIN_FUNCTION[0] ==
		$past(DATA_IN[0], 3) && BOOT_PORT_16 == BOOT_PIN_FUNCTION[0]) else $error("width");
	chk_boot_reset: assert property ($fell(RST) |-> s_boot_rst
		and BOOT_PIN_FUNCTION[1]) else $error("boot reset values");
	chk_gen_disabled: assert property ($fell(RST) |->
		SELECT_OPTION_REG == 176'h0) else $error("general option");
	chk_pullup_late: assert property ($fell(RST) |->
		DATA_PULLUP_EN ##1 !DATA_PULLUP_EN) else $error("pull-up enable");
	chk_strap_hold: assert property (!WR_EN |=>
		$stable(SELECT_PIN_FUNCTION)) else $error("pin function moved");
	chk_vec_select: assert property (s_vec_read ##0 s_boot_rst |=>
		!BOOT_SELECT_OUTPUT_N) else $error("boot select");
endmodule
bind csrc_top csrc_checker chk_u (.CORE_CLK, .RST, .DATA_IN, .WR_EN, .ACC_VALID,
	.ACC_ADDR, .ACC_RW, .ACC_SPACE, .SELECT_PIN_FUNCTION, .BOOT_PIN_FUNCTION,
	.BOOT_SELECT_BASE_REG, .BOOT_SELECT_OPTION_REG, .SELECT_OPTION_REG,
	.BOOT_PORT_16, .DATA_PULLUP_EN, .BOOT_SELECT_OUTPUT_N);
`default_nettype wire

//--- csrc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Bench signals
	logic         clk, rst, wr_en, acc_valid, acc_rw, drive, pull_en, port16, sel_n, fetched;
	logic [7:0]   level, lines;
	logic [3:0]   wr_sel;
	logic [1:0]   wr_field, acc_space, boot_pf;
	logic [15:0]  wr_data, boot_base, boot_opt;
	logic [23:0]  acc_addr;
	logic [21:0]  pin_fn;
	logic [175:0] gen_base, gen_opt;
	int           bad_count = 0, samples_checked = 0, cycles = 0;
	csrc_strap_drv part_u (.drive(drive), .level(level), .pullup_en(pull_en), .data_lines(lines));
	csrc_top dut_u (.CORE_CLK(clk), .RST(rst), .DATA_IN(lines), .DATA_PULLUP_EN(pull_en),
		.WR_EN(wr_en), .WR_SEL(wr_sel), .WR_FIELD(wr_field), .WR_DATA(wr_data),
		.ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .ACC_RW(acc_rw), .ACC_SPACE(acc_space),
		.SELECT_PIN_FUNCTION(pin_fn), .BOOT_PIN_FUNCTION(boot_pf), .BOOT_SELECT_BASE_REG(boot_base),
		.BOOT_SELECT_OPTION_REG(boot_opt), .SELECT_BASE_ADDRESS_REG(gen_base),
		.SELECT_OPTION_REG(gen_opt), .BOOT_PORT_16(port16), .BOOT_SELECT_OUTPUT_N(sel_n),
		.FIRST_FETCH_DONE(fetched));
	// Compare and count
	task chk(input string what, input logic [175:0] exp, input logic [175:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Reset with straps, then check the pin-function, port width, base and option reset values
	task t_reset(input logic drv, input logic [7:0] lv);
		logic [21:0] e;
		logic [7:0]  d;
		d = drv ? lv : 8'hFF;
		for (int i = 0; i < 11; i++) e[2*i+:2] = {d[i%7+1], 1'b1};
		@(posedge clk);
		rst <= 1'b1; drive <= drv; level <= lv;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk("pin function", e, pin_fn);
		chk("boot pin function", {1'b1, d[0]}, boot_pf);
		chk("boot port 16", d[0], port16);
		chk("boot base", 16'h0007, boot_base);
		chk("boot option", 16'h7B70, boot_opt);
		chk("general base", 176'h0, gen_base);
		chk("general option", 176'h0, gen_opt);
	endtask
	// One access to the boot decode
	task acc(input logic [23:0] a, input logic [1:0] sp, input logic exp_n);
		@(posedge clk);
		acc_valid <= 1'b1; acc_addr <= a; acc_space <= sp; acc_rw <= 1'b1;
		@(posedge clk);
		acc_valid <= 1'b0;
		#1 chk("boot select", exp_n, sel_n);
	endtask
	task t_boot_fetch;
		acc(24'h000000, 2'h2, 1'b0);
		chk("first fetch", 1'b1, fetched);
		acc(24'h0FFFFE, 2'h1, 1'b0);
		acc(24'h100000, 2'h2, 1'b1);
	endtask
	// One software write
	task wr(input logic [3:0] s, input logic [1:0] f, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1; wr_sel <= s; wr_field <= f; wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task t_sw_write;
		wr(4'hB, 2'h2, 16'h1234);
		chk("boot option write", 16'h1234, boot_opt);
		wr(4'h3, 2'h0, 16'h0000);
		wr(4'hC, 2'h0, 16'h0003);
		chk("pin after write", 22'h155515, pin_fn);
	endtask
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			close_out;
		end
	end
	// Main sequence
	initial begin
		rst = 1'b1; wr_en = 1'b0; acc_valid = 1'b0; acc_rw = 1'b1; drive = 1'b1;
		level = 8'hFF; wr_sel = 4'h0; wr_field = 2'h0; wr_data = 16'h0000;
		acc_addr = 24'h000000; acc_space = 2'h2;
		t_reset(1'b1, 8'hA5);
		t_reset(1'b0, 8'h00);
		t_boot_fetch;
		t_reset(1'b1, 8'h00);
		t_sw_write;
		close_out;
	end
endmodule
`default_nettype wire
